// ---- rtl/io_line_config.sv ----
/*
 * Isolated digital I/O line port: per-line setup of type, direction and
 * polarity, single-line and whole-group state access, per-group input
 * filter, dedicated function routing and a status/mask interrupt.
 * Assumes a plain register port driven by a master on the same clock and
 * pin inputs that are asynchronous to it (they are synchronised here).
 */

// ---------------------------------------------------------------------------
// Top module
// ---------------------------------------------------------------------------
module io_line_config
   import io_line_pkg::*;
#(
   parameter int NUM_GROUPS = 1,
   parameter int BASE_CYC   = FILT_BASE_CYC
) (
   // Clock and reset
   input  wire logic                 mclk,
   input  wire logic                 srst,
   // Register port
   input  wire logic [7:0]           addr,
   input  wire logic [31:0]          wdata,
   input  wire logic                 wr,
   input  wire logic                 rd,
   output logic      [31:0]          rdata,
   // Line pins
   input  wire logic [NUM_GROUPS*LINES_PER_GROUP-1:0] pin_in,
   output logic      [NUM_GROUPS*LINES_PER_GROUP-1:0] pin_out,
   output logic      [NUM_GROUPS*LINES_PER_GROUP-1:0] pin_oe,
   // Dedicated functions
   input  wire logic [NUM_DED_OUT-1:0] ded_out_req,
   output logic      [NUM_DED_IN-1:0]  ded_in_act,
   // Interrupt
   output logic                      irq
);

   localparam int NL = NUM_GROUPS * LINES_PER_GROUP;
   localparam int NG = NUM_GROUPS;

   typedef struct packed {
      logic [NL-1:0][TYPE_W-1:0] typ;
      logic [NL-1:0]             dir;
      logic [NL-1:0]             pol;
      logic [NL-1:0]             out_val;
      logic [NL-1:0]             in_prev;
      logic [NG-1:0][FILT_W-1:0] filt;
      logic [ST_W-1:0]           stat;
      logic [ST_W-1:0]           mask;
      logic [31:0]               rdata;
      logic [NL-1:0]             pin_out;
      logic [NL-1:0]             pin_oe;
      logic [NUM_DED_IN-1:0]     ded_in;
      logic                      irq;
   } state_s;

   state_s r;
   state_s n;

   logic [NL-1:0] flt;
   logic [NL-1:0] lin;
   logic [NL-1:0] lst;

   // -------------------------------------------------------------------------
   // Input filters, one per line
   // -------------------------------------------------------------------------
   for (genvar i = 0; i < NL; i++) begin : g_flt
      io_line_filter #(
         .BASE_CYC (BASE_CYC)
      ) u_flt (
         .mclk    (mclk),
         .srst    (srst),
         .pin_raw (pin_in[i]),
         .setting (r.filt[i / LINES_PER_GROUP]),
         .level   (flt[i])
      );
   end

   // -------------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------------
   // Address hits a group or a line number of a fitted group
   function automatic logic [8:0] decode(input logic [7:0] a,
                                         input logic [7:0] base);
      logic [8:0] res;
      logic [7:0] gnum;
      res = '0;
      for (int g = 0; g < NG; g++) begin
         gnum = base + 8'(FIRST_GROUP_NUM + g * GROUP_NUM_STEP);
         if (a == gnum)
            res = {1'b1, 1'b1, 2'(g), 5'h00};
         for (int p = 0; p < LINES_PER_GROUP; p++) begin
            if (a == gnum + 8'(p + 1))
               res = {1'b1, 1'b0, 2'(g), 5'(p)};
         end
      end
      return res;
   endfunction

   // Dedicated types fix their own direction; unknown types are illegal
   function automatic logic setup_ok(input logic [TYPE_W-1:0] t,
                                     input logic d);
      logic ok;
      ok = 1'b0;
      if (t == TYPE_GP)
         ok = 1'b1;
      else if (t >= TYPE_DIN_LO && t < TYPE_DIN_LO + 5'(NUM_DED_IN))
         ok = !d;
      else if (t >= TYPE_DOUT_LO && t < TYPE_DOUT_LO + 5'(NUM_DED_OUT))
         ok = d;
      return ok;
   endfunction

   // -------------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------------
   always_comb begin
      logic [8:0]        sdec;
      logic [8:0]        vdec;
      logic [TYPE_W-1:0] wtyp;
      logic              wdir;
      logic              wpol;
      logic              lo;
      logic [4:0]        k;
      int                idx;
      sdec = decode(addr, SETUP_BASE);
      vdec = decode(addr, STATE_BASE);
      wtyp = wdata[TYPE_LSB +: TYPE_W];
      wdir = wdata[DIR_BIT];
      wpol = wdata[POL_BIT];
      lo   = 1'b0;
      k    = '0;
      idx  = 0;
      n    = r;
      n.rdata  = '0;
      n.ded_in = '0;

      // Pin level to logical state, then pick what each line shows
      for (int i = 0; i < NL; i++) begin
         lin[i] = r.pol[i] ? flt[i] : !flt[i];
         lst[i] = r.dir[i] ? r.out_val[i] : lin[i];
      end

      // Drive outputs and route dedicated functions
      for (int i = 0; i < NL; i++) begin
         if (r.dir[i]) begin
            k  = r.typ[i] - TYPE_DOUT_LO;
            lo = (r.typ[i] == TYPE_GP) ? r.out_val[i]
                                       : ded_out_req[k[2:0]];
            n.pin_oe[i]  = 1'b1;
            n.pin_out[i] = r.pol[i] ? lo : !lo;
         end else begin
            n.pin_oe[i]  = 1'b0;
            n.pin_out[i] = 1'b0;
            if (r.typ[i] != TYPE_GP) begin
               k = r.typ[i] - TYPE_DIN_LO;
               n.ded_in[k[2:0]] = n.ded_in[k[2:0]] | lin[i];
            end
         end
      end

      // Reading the status clears it before this cycle's events set it
      if (rd && addr == STATUS_ADDR)
         n.stat = '0;

      // Any change of a general-purpose input is an event
      n.in_prev = lin;
      for (int i = 0; i < NL; i++) begin
         if (!r.dir[i] && r.typ[i] == TYPE_GP && lin[i] != r.in_prev[i])
            n.stat[ST_IN_EDGE] = 1'b1;
      end

      // Register writes
      if (wr) begin
         if (sdec[8]) begin
            if (setup_ok(wtyp, wdir)) begin
               for (int p = 0; p < LINES_PER_GROUP; p++) begin
                  idx = int'(sdec[6:5]) * LINES_PER_GROUP + p;
                  if (sdec[7] || p == int'(sdec[2:0])) begin
                     n.typ[idx] = wtyp;
                     n.dir[idx] = wdir;
                     n.pol[idx] = wpol;
                  end
               end
            end else begin
               n.stat[ST_CFG_ERR] = 1'b1;
            end
         end
         if (vdec[8]) begin
            for (int p = 0; p < LINES_PER_GROUP; p++) begin
               idx = int'(vdec[6:5]) * LINES_PER_GROUP + p;
               if (vdec[7])
                  n.out_val[idx] = wdata[p];
               else if (p == int'(vdec[2:0]))
                  n.out_val[idx] = wdata[0];
            end
         end
         for (int g = 0; g < NG; g++) begin
            if (addr == FILT_BASE + 8'(g))
               n.filt[g] = wdata[FILT_W-1:0];
         end
         if (addr == MASK_ADDR)
            n.mask = wdata[ST_W-1:0];
      end

      // Register reads; unmapped addresses read as zero
      if (rd) begin
         if (sdec[8]) begin
            idx = int'(sdec[6:5]) * LINES_PER_GROUP + int'(sdec[2:0]);
            n.rdata[TYPE_LSB +: TYPE_W] = r.typ[idx];
            n.rdata[DIR_BIT]            = r.dir[idx];
            n.rdata[POL_BIT]            = r.pol[idx];
         end
         if (vdec[8]) begin
            for (int p = 0; p < LINES_PER_GROUP; p++) begin
               idx = int'(vdec[6:5]) * LINES_PER_GROUP + p;
               if (vdec[7])
                  n.rdata[p] = lst[idx];
               else if (p == int'(vdec[2:0]))
                  n.rdata[0] = lst[idx];
            end
         end
         for (int g = 0; g < NG; g++) begin
            if (addr == FILT_BASE + 8'(g))
               n.rdata[FILT_W-1:0] = r.filt[g];
         end
         if (addr == STATUS_ADDR)
            n.rdata[ST_W-1:0] = r.stat;
         if (addr == MASK_ADDR)
            n.rdata[ST_W-1:0] = r.mask;
      end

      // Level interrupt, registered so it follows the status flops
      n.irq = |(n.stat & n.mask);
   end

   // -------------------------------------------------------------------------
   // State register
   // -------------------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (srst) begin
         r <= '0;
         for (int i = 0; i < NL; i++) begin
            r.typ[i] <= RST_TYPE;
            r.dir[i] <= RST_DIR;
            r.pol[i] <= RST_POL;
         end
         for (int g = 0; g < NG; g++)
            r.filt[g] <= FILT_RST;
      end else begin
         r <= n;
      end
   end

   // -------------------------------------------------------------------------
   // Outputs, all straight from flops
   // -------------------------------------------------------------------------
   assign rdata      = r.rdata;
   assign pin_out    = r.pin_out;
   assign pin_oe     = r.pin_oe;
   assign ded_in_act = r.ded_in;
   assign irq        = r.irq;

endmodule

// ---- rtl/io_line_pkg.sv ----
/*
 * Constants for the isolated I/O line block, plus the per-line input
 * synchroniser and pulse filter used by the top module.
 * Assumes a single 25 MHz clock, synchronous active-high reset and pin
 * levels that may change at any time relative to the clock.
 */

// ---------------------------------------------------------------------------
// Constants
// ---------------------------------------------------------------------------
// How it works
// - Six lines standard, up to 24 in sixes
// - Groups 20-50, lines group plus one to six
// - Active high: high pin reads as one
// - Active low: low pin reads as one
// - Setup holds type, direction, polarity only
// - Polarity comes from third setup field
// - Eight dedicated inputs, seven outputs, or general
// - Line or whole group access and polarity
// - Reset setup is general, input, active high
// - Dedicated type with wrong direction is rejected
// - Group value 0-63, first line is LSB
// - Per-group filter 0-7, default 7 slowest
package io_line_pkg;

   // Line and group geometry
   localparam int LINES_PER_GROUP = 6;
   localparam int MAX_GROUPS      = 4;
   localparam int FIRST_GROUP_NUM = 20;
   localparam int GROUP_NUM_STEP  = 10;

   // Register map: setup at the line or group number, state at base plus it
   localparam logic [7:0] SETUP_BASE  = 8'h00;
   localparam logic [7:0] STATE_BASE  = 8'h40;
   localparam logic [7:0] FILT_BASE   = 8'h80;
   localparam logic [7:0] STATUS_ADDR = 8'h90;
   localparam logic [7:0] MASK_ADDR   = 8'h91;

   // Setup word fields
   localparam int TYPE_LSB = 0;
   localparam int TYPE_W   = 5;
   localparam int DIR_BIT  = 8;
   localparam int POL_BIT  = 16;

   // Line type codes
   localparam logic [4:0] TYPE_GP       = 5'h00;
   localparam logic [4:0] TYPE_DIN_LO   = 5'h08;
   localparam int         NUM_DED_IN    = 8;
   localparam logic [4:0] TYPE_DOUT_LO  = 5'h10;
   localparam int         NUM_DED_OUT   = 7;

   // Reset setup of every line: general purpose, input, active high
   localparam logic [4:0] RST_TYPE = TYPE_GP;
   localparam logic       RST_DIR  = 1'b0;
   localparam logic       RST_POL  = 1'b1;

   // Interrupt status bits
   localparam int ST_CFG_ERR = 0;
   localparam int ST_IN_EDGE = 1;
   localparam int ST_W       = 2;

   // Input filter: setting 0 passes pulses of 18 us, each step doubles it
   localparam int         FILT_W        = 3;
   localparam logic [2:0] FILT_RST      = 3'h7;
   localparam int         CLK_PERIOD_NS = 40;
   localparam int         FILT_MIN_NS   = 18000;
   localparam int         FILT_BASE_CYC =
      (FILT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int         FILT_CNT_W    = 24;

endpackage

// ---------------------------------------------------------------------------
// Per-line synchroniser and pulse filter
// ---------------------------------------------------------------------------
module io_line_filter
   import io_line_pkg::*;
#(
   parameter int BASE_CYC = FILT_BASE_CYC
) (
   // Clock and reset
   input  wire logic             mclk,
   input  wire logic             srst,
   // Raw pin and filter setting
   input  wire logic             pin_raw,
   input  wire logic [FILT_W-1:0] setting,
   // Filtered pin level
   output logic                  level
);

   typedef struct packed {
      logic                  sync1;
      logic                  sync2;
      logic [FILT_CNT_W-1:0] cnt;
      logic                  level;
   } filt_s;

   filt_s r;
   filt_s n;
   logic [FILT_CNT_W-1:0] limit;

   // Level changes only after standing for the whole window
   always_comb begin
      limit   = FILT_CNT_W'(BASE_CYC) << setting;
      n       = r;
      n.sync1 = pin_raw;
      n.sync2 = r.sync1;
      if (r.sync2 != r.level) begin
         n.cnt = r.cnt + 1'b1;
         if (n.cnt >= limit) begin
            n.level = r.sync2;
            n.cnt   = '0;
         end
      end else begin
         n.cnt = '0;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst)
         r <= '0;
      else
         r <= n;
   end

   assign level = r.level;

endmodule

// ---- tb/ext_lines.sv ----
/*
 * Far-side model of the I/O lines: sensors and switches that set a level
 * on each line, and loads that follow the level the block drives.
 * Assumes the block raises pin_oe on every line it drives.
 */

// ---------------------------------------------------------------------------
// Line model
// ---------------------------------------------------------------------------
module ext_lines #(
   parameter int NL = 6
) (
   // Levels the sensors would put on undriven lines
   input  wire logic [NL-1:0] sense,
   // Block side of the lines
   input  wire logic [NL-1:0] pin_out,
   input  wire logic [NL-1:0] pin_oe,
   output logic      [NL-1:0] pin_in
);
   timeunit 1ns;
   timeprecision 1ps;

   // A driven line reads back its own level, as a real wire would
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & sense);
endmodule

// ---- tb/io_line_config_chk.sv ----
/*
 * Port checker for the I/O line block, bound to the top module.
 * Assumes the single-clock register port with read data one cycle later.
 */

// ---------------------------------------------------------------------------
// Checker
// ---------------------------------------------------------------------------
module io_line_chk
   import io_line_pkg::*;
#(
   parameter int NUM_GROUPS = 1
) (
   // Clock and reset
   input wire logic                                  mclk,
   input wire logic                                  srst,
   // Register port
   input wire logic [7:0]                            addr,
   input wire logic [31:0]                           wdata,
   input wire logic                                  wr,
   input wire logic                                  rd,
   input wire logic [31:0]                           rdata,
   // Pins and functions
   input wire logic [NUM_GROUPS*LINES_PER_GROUP-1:0] pin_in,
   input wire logic [NUM_GROUPS*LINES_PER_GROUP-1:0] pin_out,
   input wire logic [NUM_GROUPS*LINES_PER_GROUP-1:0] pin_oe,
   input wire logic [NUM_DED_OUT-1:0]                ded_out_req,
   input wire logic [NUM_DED_IN-1:0]                 ded_in_act,
   input wire logic                                  irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);

   // Read data only in the cycle after a read strobe
   property p_rd_idle; !$past(rd) |-> rdata == 32'h0; endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data outside its cycle");
   // Lines come out of reset as inputs with no interrupt
   property p_rst; $past(srst) |-> pin_oe == '0 && !irq; endproperty
   a_rst: assert property (p_rst)
      else $error("line driven after reset");
   // An input line never drives a level
   property p_oe_out; (pin_out & ~pin_oe) == '0; endproperty
   a_oe_out: assert property (p_oe_out)
      else $error("level on undriven line");
   // Dedicated input typed as output flags an error
   property p_cfg_err;
      wr && addr == 8'h15 && wdata == 32'h00010108
      ##[1:6] (rd && addr == STATUS_ADDR) |=> rdata[ST_CFG_ERR];
   endproperty
   a_cfg_err: assert property (p_cfg_err)
      else $error("illegal setup not flagged");
   // Clearing the mask drops the interrupt within two cycles
   property p_irq_mask0;
      wr && addr == MASK_ADDR && wdata[ST_W-1:0] == 2'h0 |=> ##1 !irq;
   endproperty
   a_irq_mask0: assert property (p_irq_mask0)
      else $error("interrupt while masked");
   // Filter setting is three bits wide
   property p_filt_w;
      rd && addr == FILT_BASE |=> rdata[31:FILT_W] == '0;
   endproperty
   a_filt_w: assert property (p_filt_w)
      else $error("filter setting too wide");
   // Setup word holds only type, direction and polarity
   property p_setup;
      rd && addr == 8'h15 |=> (rdata & 32'hFFFEFEE0) == 32'h0;
   endproperty
   a_setup: assert property (p_setup)
      else $error("setup word has extra bits");
   // A line of a group that is not fitted reads as zero
   property p_unfit;
      rd && addr == 8'h1F && NUM_GROUPS == 1 |=> rdata == 32'h0;
   endproperty
   a_unfit: assert property (p_unfit)
      else $error("unfitted group answered");
   // Pin changes pass the synchroniser before reaching functions
   property p_sync;
      !$stable(pin_in) |=> $stable(ded_in_act) [*2];
   endproperty
   a_sync: assert property (p_sync)
      else $error("pin change reached function too early");
endmodule

bind io_line_config io_line_chk #(.NUM_GROUPS(NUM_GROUPS)) u_chk (
   .mclk(mclk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr),
   .rd(rd), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out),
   .pin_oe(pin_oe), .ded_out_req(ded_out_req), .ded_in_act(ded_in_act),
   .irq(irq));

// ---- tb/tb_top.sv ----
/*
 * Self-checking bench for the I/O line block: register tasks, line model.
 * Assumes one 25 MHz clock and a short filter base count for speed.
 */
module tb_top
   import io_line_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        mclk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, irq;
   logic [7:0]  addr = 8'h00, ded_in_act;
   logic [31:0] wdata = 32'h0, rdata;
   logic [5:0]  pin_in, pin_out, pin_oe, sense = 6'h23;
   logic [6:0]  ded_out_req = 7'h00;
   logic [31:0] bad [3] = '{32'h00010108, 32'h00010010, 32'h00010117};
   int          n_errors = 0, total_checks = 0;

   always #20 mclk = ~mclk;

   // Short base count keeps the slowest filter at 256 cycles
   io_line_config #(.NUM_GROUPS(1), .BASE_CYC(2)) u_dut (
      .mclk(mclk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe(pin_oe), .ded_out_req(ded_out_req),
      .ded_in_act(ded_in_act), .irq(irq));
   ext_lines #(.NL(6)) u_ext (
      .sense(sense), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));

   // ------------------------------------------------------------------------
   // Register port tasks and comparison
   // ------------------------------------------------------------------------
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      addr <= a; wdata <= d; wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   // Data is taken mid-cycle, where the one-cycle answer has settled
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge mclk);
      addr <= a; rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      @(negedge mclk);
      d = rdata;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      rd_reg(a, d);
      chk(d, exp);
   endtask
   task automatic end_sim;
      $display("checks=%0d errors=%0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // ------------------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------------------
   initial begin
      repeat (4) @(posedge mclk);
      srst <= 1'b0;
      rchk(8'h15, 32'h00010000);
      rchk(8'h14, 32'h00010000);
      rchk(FILT_BASE, 32'h7);
      rchk(8'h1F, 32'h0);
      rchk(MASK_ADDR, 32'h0);
      wr_reg(FILT_BASE, 32'h0);
      repeat (300) @(posedge mclk);
      rchk(8'h54, 32'h23);
      rchk(8'h55, 32'h1);
      rchk(8'h57, 32'h0);
      // Slowest filter: a 100-cycle dip is swallowed, a long one is not
      wr_reg(FILT_BASE, 32'h7);
      sense <= 6'h22;
      repeat (100) @(posedge mclk);
      sense <= 6'h23;
      repeat (10) @(posedge mclk);
      rchk(8'h55, 32'h1);
      sense <= 6'h22;
      repeat (300) @(posedge mclk);
      rchk(8'h55, 32'h0);
      sense <= 6'h23;
      repeat (300) @(posedge mclk);
      // Group set active low, then one line back to active high
      wr_reg(8'h14, 32'h0);
      repeat (4) @(posedge mclk);
      rchk(8'h54, 32'h1C);
      wr_reg(8'h15, 32'h00010000);
      repeat (4) @(posedge mclk);
      rchk(8'h54, 32'h1D);
      // Type and direction that disagree, or an unknown type, are refused and flagged
      // Input changes since reset, line 21 flip among them, set the edge bit only
      rchk(STATUS_ADDR, 32'h2);
      wr_reg(MASK_ADDR, 32'h1);
      foreach (bad[i]) begin
         wr_reg(8'h15, bad[i]);
         repeat (2) @(posedge mclk);
         chk({31'h0, irq}, 32'h1);
         rchk(STATUS_ADDR, 32'h1);
         rchk(8'h15, 32'h00010000);
         repeat (2) @(posedge mclk);
         chk({31'h0, irq}, 32'h0);
      end
      // Every dedicated input function on line 22
      for (int k = 0; k < NUM_DED_IN; k++) begin
         wr_reg(8'h16, 32'h00010008 + k);
         repeat (4) @(posedge mclk);
         chk({24'h0, ded_in_act}, 32'h1 << k);
         rchk(8'h16, 32'h00010008 + k);
      end
      wr_reg(8'h16, 32'h00010000);
      // Every dedicated output function on line 26, others held opposite
      for (int j = 0; j < NUM_DED_OUT; j++) begin
         wr_reg(8'h1A, 32'h00010110 + j);
         ded_out_req <= 7'h1 << j;
         repeat (3) @(posedge mclk);
         chk({30'h0, pin_oe[5], pin_out[5]}, 32'h3);
         ded_out_req <= ~(7'h1 << j);
         repeat (3) @(posedge mclk);
         chk({30'h0, pin_oe[5], pin_out[5]}, 32'h2);
      end
      // Whole-group output value, active low then active high
      ded_out_req <= 7'h0;
      wr_reg(8'h14, 32'h00000100);
      wr_reg(8'h54, 32'd35);
      repeat (3) @(posedge mclk);
      chk({20'h0, pin_oe, pin_out}, 32'hFDC);
      rchk(8'h54, 32'h23);
      wr_reg(8'h14, 32'h00010100);
      repeat (3) @(posedge mclk);
      chk({20'h0, pin_oe, pin_out}, 32'hFE3);
      // Masked error: flagged in status but no interrupt
      wr_reg(MASK_ADDR, 32'h0);
      wr_reg(8'h15, bad[0]);
      repeat (3) @(posedge mclk);
      chk({31'h0, irq}, 32'h0);
      rchk(STATUS_ADDR, 32'h1);
      rchk(8'h15, 32'h00010100);
      end_sim;
   end

   // Watchdog well past the expected run of about 1200 cycles
   initial begin
      #400000;
      n_errors++;
      end_sim;
   end
endmodule
